// [common/flash_seq_pkg.sv]
// shared constants and types of the flash command sequencer
package flash_seq_pkg;
	// register word indices; byte address is four times the index
	localparam logic [5:0] IX_INDEX  = 6'h02;
	localparam logic [5:0] IX_CONFIG = 6'h04;
	localparam logic [5:0] IX_STATUS = 6'h06;
	localparam logic [5:0] IX_FAULT  = 6'h07;
	localparam logic [5:0] IX_OBJECT = 6'h0A;
	// status field positions
	localparam int ST_COMPLETE = 7;
	localparam int ST_ACC_ERR  = 5;
	localparam int ST_PVIOL    = 4;
	localparam int ST_BUSY     = 3;
	localparam int ST_VERR     = 1;
	localparam int ST_NCVERR   = 0;
	// fault configuration and fault status positions
	localparam int CFG_DOUBLE_EN = 1;
	localparam int CFG_SINGLE_EN = 0;
	localparam int FS_DF         = 1;
	localparam int FS_SF         = 0;
	// reset value of the complete flag
	localparam logic COMPLETE_RST = 1'b1;
	// command codes
	localparam logic [7:0] CMD_EVB    = 8'h02;
	localparam logic [7:0] CMD_RDONCE = 8'h04;
	localparam logic [7:0] CMD_PGM    = 8'h06;
	localparam logic [7:0] CMD_OTP    = 8'h07;
	// command word index expected at launch
	localparam logic [2:0] IXW_EVB  = 3'h0;
	localparam logic [2:0] IXW_RD   = 3'h1;
	localparam logic [2:0] IXW_FULL = 3'h5;
	// block selection codes
	localparam logic [1:0] SEL_EE  = 2'h0;
	localparam logic [1:0] SEL_BAD = 2'h1;
	// sizes and limits
	localparam logic [15:0] OTP_LAST = 16'h0007;
	localparam logic [17:0] PF_BYTES = 18'h08000;
	localparam logic [17:0] PF_LAST  = 18'h03FFF;
	localparam logic [17:0] EE_LAST  = 18'h003FF;
	localparam logic [15:0] BLANK    = 16'hFFFF;

	// byte address of a register index
	function automatic logic [7:0] reg_addr(logic [5:0] ix);
		return {ix, 2'b00};
	endfunction

	// sequencer phases
	typedef enum logic [2:0] {S_IDLE, S_CHECK, S_READ, S_WRITE, S_VERIFY, S_DONE} seq_e;
	typedef logic [3:0][15:0] phrase_t;

	// array request and answer
	typedef struct packed {
		logic        req;
		logic        we;
		logic        eeprom;
		logic [17:0] addr;
		logic [15:0] wdata;
	} mem_req_s;
	typedef struct packed {
		logic        ack;
		logic [15:0] rdata;
		logic        sbe;
		logic        dbe;
	} mem_rsp_s;

	// whole sequencer state
	typedef struct packed {
		seq_e            st;
		logic [2:0]      idx;
		logic [5:0][15:0] obj;
		logic            complete;
		logic            acc_err;
		logic            pviol;
		logic            verr;
		logic            ncverr;
		logic            dff;
		logic            sff;
		logic [1:0]      cfg;
		logic [17:0]     cnt;
		logic [17:0]     last;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
		logic            irq;
		logic            pinv;
		mem_req_s        mem;
	} seq_s;

	// one-time area contents
	typedef struct packed {
		logic [7:0][3:0][15:0] ph;
	} otp_s;
endpackage

// [hdl/otp_area_store.sv]
// one-time programmable area of eight phrases
`timescale 1ns/1ps
`default_nettype none
module otp_area_store (
	// clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// program port
	input  wire logic                   wr_en,
	input  wire logic [2:0]             phrase,
	input  wire flash_seq_pkg::phrase_t wdata,
	// read port
	output      flash_seq_pkg::phrase_t rdata,
	output      logic                   blank
);
	import flash_seq_pkg::*;

	otp_s q;   // stored phrases
	otp_s d;   // next contents

	// programming can only clear bits, as a real cell would
	always_comb begin
		d = q;
		if (wr_en) begin
			d.ph[phrase] = q.ph[phrase] & wdata;
		end
	end

	// erased state after reset stands in for the nonvolatile array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign rdata = q.ph[phrase];
	assign blank = &q.ph[phrase];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	otp_blank_wr_a:
		assert property (wr_en |-> blank ##1 (q.ph[$past(phrase)] == $past(wdata)))
		else $error("one-time phrase written while not blank");
endmodule
`default_nettype wire

// [hdl/flash_command_sequencer.sv]
// flash command sequencer with apb register access
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer (
	// clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output      logic [31:0]            prdata,
	output      logic                   pready,
	output      logic                   pslverr,
	// chip state, same clock
	input  wire logic                   pstore_protected,
	input  wire logic                   read_once_allowed,
	// flash array port
	output      flash_seq_pkg::mem_req_s mem_o,
	input  wire flash_seq_pkg::mem_rsp_s mem_i,
	// requests to the rest of the chip
	output      logic                   fault_irq,
	output      logic                   pstore_read_invalid
);
	import flash_seq_pkg::*;

	seq_s        q;          // registered state
	seq_s        d;          // next state
	logic        wr;         // write takes effect this edge
	logic        setup;      // setup phase of any transfer
	logic        wr_stat;    // status write
	logic [7:0]  cmd;        // loaded command code
	logic [1:0]  sel;        // block selection code
	logic [17:0] base;       // phrase address for programming
	logic        otp_we;     // one-time area program strobe
	phrase_t     otp_rd;     // addressed one-time phrase
	logic        otp_blank;  // addressed phrase still erased
	logic [7:0]  status;     // status register image

	// decode of the bus and the loaded command
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & q.pready & pwrite;
	assign wr_stat = wr & (paddr == reg_addr(IX_STATUS));
	assign cmd     = q.obj[0][15:8];
	assign sel     = q.obj[0][1:0];
	assign base    = {q.obj[0][1:0], q.obj[1]};
	assign otp_we  = (q.st == S_WRITE) & (cmd == CMD_OTP);

	always_comb begin
		status            = '0;
		status[ST_COMPLETE] = q.complete;
		status[ST_ACC_ERR]  = q.acc_err;
		status[ST_PVIOL]  = q.pviol;
		status[ST_BUSY]   = (q.st != S_IDLE);
		status[ST_VERR]   = q.verr;
		status[ST_NCVERR] = q.ncverr;
	end

	// command object slot of data word n
	function automatic logic [2:0] word_ix(logic [1:0] n);
		return {1'b0, n} + 3'h2;
	endfunction

	// fold one array read into the verify and fault flags
	function automatic seq_s note_read(seq_s s, mem_rsp_s r, logic [15:0] want);
		seq_s t;
		t = s;
		// uncorrectable fault or mismatch sets both
		if (r.dbe || r.rdata != want) begin
			t.verr   = 1'b1;
			t.ncverr = 1'b1;
		end
		// corrected fault still counts as a read error
		if (r.sbe) begin
			t.verr = 1'b1;
		end
		t.dff = t.dff | r.dbe;
		t.sff = t.sff | r.sbe;
		return t;
	endfunction

	// the one-time area
	otp_area_store u_otp (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (otp_we),
		.phrase  (q.obj[1][2:0]),
		.wdata   (q.obj[5:2]),
		.rdata   (otp_rd),
		.blank   (otp_blank)
	);

	// all next-state logic: bus first, sequencer second so hardware sets win
	always_comb begin
		d         = q;
		d.pready  = setup;
		d.pslverr = 1'b0;
		d.prdata  = '0;
		// read data and error prepared in setup, shown in the access phase
		if (setup) begin
			case (paddr)
				reg_addr(IX_INDEX): begin
					d.prdata = {29'h0, q.idx};
				end
				reg_addr(IX_CONFIG): begin
					d.prdata = {30'h0, q.cfg};
				end
				reg_addr(IX_STATUS): begin
					d.prdata = {24'h0, status};
				end
				reg_addr(IX_FAULT): begin
					d.prdata = {30'h0, q.dff, q.sff};
				end
				reg_addr(IX_OBJECT): begin
					d.prdata = (q.idx <= IXW_FULL) ? {16'h0, q.obj[q.idx]} : 32'h0;
				end
				default: begin
					d.pslverr = 1'b1;
				end
			endcase
		end
		// register writes at the access edge
		if (wr) begin
			case (paddr)
				reg_addr(IX_INDEX), reg_addr(IX_OBJECT): begin
					// no command write while protection flag stands
					if (!q.complete) begin
						d.acc_err = 1'b1;
					end else if (!q.pviol) begin
						if (paddr == reg_addr(IX_INDEX)) begin
							d.idx = pwdata[2:0];
						end else if (q.idx <= IXW_FULL) begin
							d.obj[q.idx] = pwdata[15:0];
						end else begin
							d.acc_err = 1'b1;
						end
					end
				end
				reg_addr(IX_CONFIG): begin
					d.cfg = pwdata[1:0];
				end
				reg_addr(IX_STATUS): begin
					// error flags clear on one only
					if (pwdata[ST_ACC_ERR]) begin
						d.acc_err = 1'b0;
					end
					if (pwdata[ST_PVIOL]) begin
						d.pviol = 1'b0;
					end
					// launch only from a clean complete state
					if (pwdata[ST_COMPLETE] && q.complete && !q.acc_err && !q.pviol) begin
						d.complete = 1'b0;
						d.verr   = 1'b0;
						d.ncverr = 1'b0;
						d.st     = S_CHECK;
					end
				end
				reg_addr(IX_FAULT): begin
					if (pwdata[FS_DF]) begin
						d.dff = 1'b0;
					end
					if (pwdata[FS_SF]) begin
						d.sff = 1'b0;
					end
				end
				default: begin
					d.pslverr = 1'b0;
				end
			endcase
		end
		// sequencer
		case (q.st)
			S_IDLE: begin
				d.mem.req = 1'b0;
			end
			S_CHECK: begin
				d.st = S_DONE;
				d.cnt = '0;
				case (cmd)
					CMD_EVB: begin
						if (q.idx != IXW_EVB || sel == SEL_BAD) begin
							d.acc_err = 1'b1;
						end else begin
							d.mem    = '0;
							d.mem.req    = 1'b1;
							d.mem.eeprom = (sel == SEL_EE);
							d.last   = (sel == SEL_EE) ? EE_LAST : PF_LAST;
							d.st     = S_READ;
						end
					end
					CMD_PGM: begin
						if (q.idx != IXW_FULL || base[2:0] != 3'h0 || base >= PF_BYTES) begin
							d.acc_err = 1'b1;
						end else if (pstore_protected) begin
							d.pviol = 1'b1;
						end else begin
							d.mem    = '0;
							d.mem.req   = 1'b1;
							d.mem.we    = 1'b1;
							d.mem.addr  = base;
							d.mem.wdata = q.obj[word_ix(2'h0)];
							d.st     = S_WRITE;
						end
					end
					CMD_OTP: begin
						if (q.idx != IXW_FULL || q.obj[1] > OTP_LAST) begin
							d.acc_err = 1'b1;
						end else if (!otp_blank) begin
							// already programmed, report and leave it
							d.verr   = 1'b1;
							d.ncverr = 1'b1;
						end else begin
							d.st = S_WRITE;
						end
					end
					CMD_RDONCE: begin
						if (q.idx != IXW_RD || q.obj[1] > OTP_LAST || !read_once_allowed) begin
							d.acc_err = 1'b1;
						end else begin
							d.st = S_READ;
						end
					end
					default: begin
						d.acc_err = 1'b1;
					end
				endcase
			end
			S_READ: begin
				if (cmd == CMD_RDONCE) begin
					// phrase lands in the data words
					d.obj[5:2] = otp_rd;
					d.st       = S_DONE;
				end else if (mem_i.ack) begin
					// any non-blank word fails the block
					d = note_read(d, mem_i, BLANK);
					if (q.cnt == q.last) begin
						d.mem.req = 1'b0;
						d.st      = S_DONE;
					end else begin
						d.cnt      = q.cnt + 18'h1;
						d.mem.addr = q.mem.addr + 18'h2;
					end
				end
			end
			S_WRITE: begin
				if (cmd == CMD_OTP) begin
					d.st = S_VERIFY;
				end else if (mem_i.ack) begin
					// four words, then read-back from the base
					if (q.cnt[1:0] == 2'h3) begin
						d.mem.we   = 1'b0;
						d.mem.addr = base;
						d.cnt      = '0;
						d.st       = S_VERIFY;
					end else begin
						d.cnt       = q.cnt + 18'h1;
						d.mem.addr  = q.mem.addr + 18'h2;
						d.mem.wdata = q.obj[word_ix(q.cnt[1:0] + 2'h1)];
					end
				end
			end
			S_VERIFY: begin
				if (cmd == CMD_OTP) begin
					if (otp_rd != q.obj[5:2]) begin
						d.verr   = 1'b1;
						d.ncverr = 1'b1;
					end
					d.st = S_DONE;
				end else if (mem_i.ack) begin
					d = note_read(d, mem_i, q.obj[word_ix(q.cnt[1:0])]);
					if (q.cnt[1:0] == 2'h3) begin
						d.mem.req = 1'b0;
						d.st      = S_DONE;
					end else begin
						d.cnt      = q.cnt + 18'h1;
						d.mem.addr = q.mem.addr + 18'h2;
					end
				end
			end
			S_DONE: begin
				// complete flag rises with return to idle
				d.complete = 1'b1;
				d.st   = S_IDLE;
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase
		// fault requests gated by their enables
		d.irq  = (d.cfg[CFG_DOUBLE_EN] & d.dff) | (d.cfg[CFG_SINGLE_EN] & d.sff);
		// program store data invalid while read-once runs
		d.pinv = (d.st == S_CHECK || d.st == S_READ) && (d.obj[0][15:8] == CMD_RDONCE);
	end

	// state register; complete flag is the only bit set at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q      <= '0;
			q.complete <= COMPLETE_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign prdata              = q.prdata;
	assign pready              = q.pready;
	assign pslverr             = q.pslverr;
	assign mem_o               = q.mem;
	assign fault_irq           = q.irq;
	assign pstore_read_invalid = q.pinv;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// launch write accepted
	sequence s_launch;
		wr_stat && pwdata[ST_COMPLETE] && q.complete && !q.acc_err && !q.pviol;
	endsequence
	// failed check ends with error then completion
	sequence s_fail_end;
		q.acc_err && q.st == S_DONE ##1 q.complete && q.st == S_IDLE;
	endsequence

	launch_clears_a:
		assert property (s_launch |=> !q.complete && q.st == S_CHECK)
		else $error("launch did not start the command");
	busy_low_flag_a:
		assert property (q.st != S_IDLE |-> !q.complete)
		else $error("complete flag high while busy");
	err_blocks_launch_a:
		assert property (wr_stat && pwdata[ST_COMPLETE] && q.acc_err |=> q.st != S_CHECK)
		else $error("launch taken while access error set");
	pviol_block_a:
		assert property (wr && paddr == reg_addr(IX_INDEX) && q.pviol |=> $stable(q.idx))
		else $error("command write taken while protection flag set");
	evb_bad_sel_a:
		assert property (q.st == S_CHECK && cmd == CMD_EVB && sel == SEL_BAD |=> s_fail_end)
		else $error("invalid block selection not refused");
	evb_no_pviol_a:
		assert property (q.st != S_IDLE && cmd == CMD_EVB |-> !q.pviol)
		else $error("protection flag during erase verify");
	pgm_misalign_a:
		assert property (q.st == S_CHECK && cmd == CMD_PGM && base[2:0] != 3'h0
			|=> !q.mem.req ##0 s_fail_end)
		else $error("misaligned program address not refused");
	otp_used_a:
		assert property (q.st == S_CHECK && cmd == CMD_OTP && q.idx == IXW_FULL
			&& q.obj[1] <= OTP_LAST && !otp_blank
			|=> q.verr && q.ncverr && !otp_we ##1 q.complete)
		else $error("programmed one-time phrase not reported");
	rdonce_mode_a:
		assert property (q.st == S_CHECK && cmd == CMD_RDONCE && !read_once_allowed
			|=> s_fail_end)
		else $error("read-once in wrong mode not refused");
	irq_double_a:
		assert property (q.dff && q.cfg[CFG_DOUBLE_EN] |-> fault_irq)
		else $error("double fault request missing");
	irq_single_a:
		assert property (!q.dff && !q.cfg[CFG_SINGLE_EN] |-> !fault_irq)
		else $error("single fault request while disabled");
	rdonce_inval_a:
		assert property (q.st == S_READ && cmd == CMD_RDONCE |-> pstore_read_invalid)
		else $error("program store not marked invalid");
endmodule
`default_nettype wire

// [sim/flash_command_sequencer_tb.sv]
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer_tb;
	import flash_seq_pkg::*;
	logic                     pclk;       // bus clock, 40 ns
	logic                     presetn;    // async reset, low active
	logic                     psel;       // apb select
	logic                     penable;    // apb access phase
	logic                     pwrite;     // apb direction
	logic [7:0]               paddr;      // apb byte address
	logic [31:0]              pwdata;     // apb write data
	logic [31:0]              prdata;     // apb read data
	logic                     pready;     // apb answer
	logic                     pslverr;    // apb error answer
	logic                     prot;       // program store protected
	logic                     ro_ok;      // read-once allowed in this mode
	logic                     irq;        // fault interrupt request
	logic                     rd_inv;     // program store reads invalid
	mem_req_s                 mem_o;      // array request
	mem_rsp_s                 mem_i;      // array answer
	logic [15:0]              mem [logic [18:0]]; // array image, blank if absent
	logic [15:0]              rnd;        // stimulus lfsr
	logic [15:0]              ar = 16'd52161; // ack lfsr, one driver only
	logic                     ack_en = 1'b0;  // array ready this cycle
	logic                     sbe_inj;    // corrected fault on every read
	logic                     dbe_inj;    // uncorrectable fault on every read
	logic                     seen_inv;   // invalid-read flag was seen high
	logic                     se;         // last pslverr taken
	logic [31:0]              rd;         // last read data taken
	logic [15:0]              w [4];      // phrase words under test
	logic [15:0]              base;       // phrase address under test
	logic [2:0]               ph;         // one-time phrase index
	int                       n_mismatch; // mismatches
	int                       n_tests;    // comparisons
	int                       n_rd;       // array reads of the last command
	int                       cyc;        // cycles for the hang guard

	flash_command_sequencer DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pstore_protected(prot),
		.read_once_allowed(ro_ok), .mem_o(mem_o), .mem_i(mem_i),
		.fault_irq(irq), .pstore_read_invalid(rd_inv)
	);

	// free-running bus clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// array model word, erased cells read all ones
	function automatic logic [15:0] rdv(logic [18:0] k);
		return mem.exists(k) ? mem[k] : 16'hFFFF;
	endfunction

	// array answer: data is scrambled outside ack so stale values never match
	always_comb begin
		mem_i.ack = mem_o.req & ack_en;
		mem_i.rdata = rdv({mem_o.eeprom, mem_o.addr}) ^ {16{~mem_i.ack}};
		mem_i.sbe = mem_i.ack & sbe_inj;
		mem_i.dbe = mem_i.ack & dbe_inj;
	end

	// array writes, read count, random stalls and hang guard
	always @(posedge pclk) begin
		ar <= lfsr(ar);
		ack_en <= ar[0] | ar[1];
		if (mem_i.ack && mem_o.we)
			mem[{mem_o.eeprom, mem_o.addr}] = mem_o.wdata;
		if (mem_i.ack && !mem_o.we)
			n_rd++;
		if (rd_inv === 1'b1)
			seen_inv = 1'b1;
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic close_out();
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer: setup, access held until pready, then one idle edge
	task automatic apb(logic wr, logic [5:0] ix, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {ix, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no assumed latency; only the hang guard ends a stuck wait
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(logic [5:0] ix, logic [31:0] exp);
		apb(1'b0, ix, 32'h0);
		chk(rd, exp);
	endtask

	// loads object words 0..n-1, leaving the index at n-1
	task automatic cmd(logic [15:0] o [6], int n);
		for (int i = 0; i < n; i++) begin
			apb(1'b1, IX_INDEX, 32'(i));
			apb(1'b1, IX_OBJECT, {16'h0, o[i]});
		end
	endtask

	// launch, poll for completion under a bound, compare final status
	task automatic go(logic [31:0] exp);
		int n;
		n = 0;
		n_rd = 0;
		seen_inv = 1'b0;
		apb(1'b1, IX_STATUS, 32'h80);
		rd = 32'h0;
		while (rd[7] !== 1'b1 && n < 30000) begin
			apb(1'b0, IX_STATUS, 32'h0);
			n++;
		end
		chk(rd, exp);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{prot, sbe_inj, dbe_inj, presetn} = '0;
		ro_ok = 1'b1;
		rnd = 16'd52161;
		{n_mismatch, n_tests, n_rd, cyc} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(IX_STATUS, 32'h80);
		// read-only and unused status bits ignore writes
		apb(1'b1, IX_STATUS, 32'h4F);
		rchk(IX_STATUS, 32'h80);
		apb(1'b0, 6'h3F, 32'h0);
		chk({rd[30:0], se}, 32'h1);
		// eeprom and program store blank checks, full walks
		cmd('{16'h0200, 0, 0, 0, 0, 0}, 1);
		go(32'h80);
		chk(n_rd, 1024);
		cmd('{16'h0202, 0, 0, 0, 0, 0}, 1);
		go(32'h80);
		chk(n_rd, 16384);
		// invalid selection, then launch refused while the error stands
		cmd('{16'h0201, 0, 0, 0, 0, 0}, 1);
		go(32'hA0);
		apb(1'b1, IX_STATUS, 32'h80);
		rchk(IX_STATUS, 32'hA0);
		apb(1'b1, IX_STATUS, 32'h20);
		rchk(IX_STATUS, 32'h80);
		// blank check launched with the wrong index
		cmd('{16'h0200, 0, 0, 0, 0, 0}, 2);
		go(32'hA0);
		apb(1'b1, IX_STATUS, 32'h20);
		// unknown command code is an illegal command
		cmd('{16'h0100, 0, 0, 0, 0, 0}, 1);
		go(32'hA0);
		apb(1'b1, IX_STATUS, 32'h20);
		rnd = lfsr(rnd);
		base = {1'b0, rnd[11:0], 3'b000};
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			w[i] = rnd;
		end
		cmd('{16'h0600, base, w[0], w[1], w[2], w[3]}, 6);
		go(32'h80);
		for (int i = 0; i < 4; i++)
			chk({16'h0, rdv(19'(base + 2 * i))}, {16'h0, w[i]});
		// misaligned, then protected target
		cmd('{16'h0600, base | 16'h1, w[0], w[1], w[2], w[3]}, 6);
		go(32'hA0);
		apb(1'b1, IX_STATUS, 32'h20);
		prot <= 1'b1;
		cmd('{16'h0600, base, w[0], w[1], w[2], w[3]}, 6);
		go(32'h90);
		apb(1'b1, IX_STATUS, 32'h80);
		rchk(IX_STATUS, 32'h90);
		// command write sequence refused while protection flag stands
		apb(1'b1, IX_INDEX, 32'h2);
		rchk(IX_INDEX, 32'h5);
		apb(1'b1, IX_STATUS, 32'h10);
		prot <= 1'b0;
		// program store no longer blank
		cmd('{16'h0203, 0, 0, 0, 0, 0}, 1);
		go(32'h83);
		// program once, second attempt refused, then read back
		// load once; repeat is deliberate misuse
		ph = rnd[2:0];
		cmd('{16'h0700, {13'h0, ph}, w[0], w[1], w[2], w[3]}, 6);
		go(32'h80);
		cmd('{16'h0700, {13'h0, ph}, ~w[0], ~w[1], ~w[2], ~w[3]}, 6);
		go(32'h83);
		cmd('{16'h0400, {13'h0, ph}, 0, 0, 0, 0}, 2);
		go(32'h80);
		chk(32'(seen_inv), 32'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, IX_INDEX, 32'(i + 2));
			rchk(IX_OBJECT, {16'h0, w[i]});
		end
		// read-once with bad phrase, then in a mode that forbids it
		cmd('{16'h0400, 16'h0008, 0, 0, 0, 0}, 2);
		go(32'hA0);
		apb(1'b1, IX_STATUS, 32'h20);
		ro_ok <= 1'b0;
		cmd('{16'h0400, {13'h0, ph}, 0, 0, 0, 0}, 2);
		go(32'hA0);
		apb(1'b1, IX_STATUS, 32'h20);
		ro_ok <= 1'b1;
		// corrected faults: general verify flag and single-fault request
		apb(1'b1, IX_CONFIG, 32'h1);
		sbe_inj <= 1'b1;
		cmd('{16'h0200, 0, 0, 0, 0, 0}, 1);
		go(32'h82);
		sbe_inj <= 1'b0;
		rchk(IX_FAULT, 32'h1);
		chk(32'(irq), 32'h1);
		apb(1'b1, IX_CONFIG, 32'h0);
		rchk(IX_CONFIG, 32'h0);
		chk(32'(irq), 32'h0);
		apb(1'b1, IX_FAULT, 32'h3);
		rchk(IX_FAULT, 32'h0);
		// uncorrectable faults: both verify flags and double-fault request
		apb(1'b1, IX_CONFIG, 32'h2);
		dbe_inj <= 1'b1;
		cmd('{16'h0200, 0, 0, 0, 0, 0}, 1);
		go(32'h83);
		dbe_inj <= 1'b0;
		apb(1'b0, IX_FAULT, 32'h0);
		chk(rd & 32'h2, 32'h2);
		chk(32'(irq), 32'h1);
		apb(1'b1, IX_CONFIG, 32'h0);
		rchk(IX_CONFIG, 32'h0);
		chk(32'(irq), 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
